// ### core/adc_conv_cal_sequencer.sv
/*
  Conversion and calibration sequencer of a successive-approximation converter.
  Holds the hold-strobe start logic, the divide-by-four conversion clock, the
  conversion-done and end-of-track outputs, hardware and software resets, and
  the full, burst and interleave calibration modes.
  Assumes clk is the 25 MHz master clock and that all control pins are
  asynchronous to it; they pass a two-flop synchroniser before use.
*/
// Function
// R1: Hold falling edge holds input, starts a conversion, then returns to tracking.
// R2: Conversion-done falls on valid data, rises within four clocks of read/start.
// R3: Bus write to start conversion must have byte/register select high.
// R4: Controller holds burst and interleave requests valid while chip is selected.
// R5: Controller waits six clocks plus acquisition time before next conversion.
// R6: Conversion logic runs on master clock divided by four.
// R7: Asynchronous conversion takes 49 to 53 clocks; throughput per acquisition rule.
// R8: End-of-track falls 15 clocks after conversion-done, on conversion clock.
// R9: Looping end-of-track to hold gives fixed 49-clock conversions.
// R10: External counter from conversion-done may trigger hold at slow clocks.
// R11: Reset overrides everything, abandons activity and starts full calibration.
// R12: Reset pin clears logic; release starts 1,443,840-clock full calibration.
// R13: Chip select, select line and hold all low cause software reset.
// R14: Conversion-done stays high during reset, falls when calibration completes.
// R15: With permanent data reads selected, conversion-done stays high after reset.
// R16: Burst starts on request with select low, latched on select rise, repeats.
// R17: Interrupted burst keeps progress and continues from where it stopped.
// R18: Controller waits 26 clocks plus acquisition after burst request drops.
// R19: Conversion-done falls when the final experiment of a stopped burst ends.
// R20: Interleave appends one experiment per conversion; update after full sequence.
// R21: Interleave active by low request with select, lengthens conversion 20 clocks.
// R22: Burst overrides interleave and continues the shared experiment sequence.
// R23: Divider runs freely; pending hold starts conversion at next phase boundary.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_conv_cal_sequencer #(
  parameter int unsigned FULLCAL_CLKS = `SEQ_FULLCAL_CLKS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Sampling and bus control pins
  input  wire logic hold_n,
  input  wire logic cs_n,
  input  wire logic rd_n,
  input  wire logic byte_reg_select,
  // Calibration request pins
  input  wire logic cal_request,
  input  wire logic interleave_cal_n,
  // Sequencing outputs
  output logic      conv_done_n,
  output logic      track_done_n,
  // Status outputs
  output logic      tracking,
  output logic      converting,
  output logic      calibrating,
  output logic      xfer_update
);

  // Full calibration reload, cut to the counter width
  localparam logic [`SEQ_CNT_W-1:0] FULLCAL_LOAD = `SEQ_CNT_W'(FULLCAL_CLKS - 1);

  // Synchronised pins
  logic [`SEQ_SYNC_W-1:0] pinSync;
  logic                   holdS;
  logic                   csS;
  logic                   rdS;
  logic                   selS;
  logic                   calS;
  logic                   ilvS;

  // Sequencer state
  adc_seq_pkg::seq_state_e state;
  adc_seq_pkg::seq_state_e next_state;
  logic [`SEQ_CNT_W-1:0]   cnt;
  logic [`SEQ_CNT_W-1:0]   next_cnt;
  logic [`SEQ_DIV_W-1:0]   phase;
  logic [`SEQ_DIV_W-1:0]   next_phase;
  logic                    holdPending;
  logic                    next_holdPending;
  logic                    convIlv;
  logic                    next_convIlv;
  logic [`SEQ_EXP_W-1:0]   expIdx;
  logic [`SEQ_EXP_W-1:0]   next_expIdx;
  logic                    next_xferUpdate;

  // Output timing state
  logic                     next_convDoneN;
  logic                     next_trackDoneN;
  logic [`SEQ_EOT_W-1:0]    eotCnt;
  logic [`SEQ_EOT_W-1:0]    next_eotCnt;
  logic                     eotRun;
  logic                     next_eotRun;
  logic [`SEQ_EOC_AGE_W-1:0] eocAge;
  logic [`SEQ_EOC_AGE_W-1:0] next_eocAge;

  // Pin history and latched calibration requests
  logic holdPrev;
  logic csPrev;
  logic calLatch;
  logic ilvLatch;
  logic next_holdPrev;
  logic next_csPrev;
  logic next_calLatch;
  logic next_ilvLatch;

  // Decoded conditions
  logic tick;
  logic holdFall;
  logic softReset;
  logic dataRead;
  logic burstReq;
  logic ilvReq;

  // Step to the next experiment; wraps at the end of the sequence
  function automatic logic [`SEQ_EXP_W-1:0] exp_next(input logic [`SEQ_EXP_W-1:0] idx);
    exp_next = (idx == `SEQ_EXP_LAST) ? '0 : idx + `SEQ_EXP_W'(1);
  endfunction : exp_next

  // Sequence complete when the last experiment ends
  function automatic logic exp_wraps(input logic [`SEQ_EXP_W-1:0] idx);
    exp_wraps = (idx == `SEQ_EXP_LAST);
  endfunction : exp_wraps

  // Control pins cross into the master clock domain
  adc_seq_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .pinIn   ({hold_n, cs_n, rd_n, byte_reg_select, cal_request, interleave_cal_n}),
    .pinSync (pinSync)
  );

  // Unpack synchronised pins and decode bus conditions
  always_comb begin
    holdS     = pinSync[5];
    csS       = pinSync[4];
    rdS       = pinSync[3];
    selS      = pinSync[2];
    calS      = pinSync[1];
    ilvS      = pinSync[0];
    tick      = (phase == `SEQ_DIV_LAST);                // R6 R23
    holdFall  = holdPrev && !holdS;                      // R1
    softReset = !csS && !selS && !holdS;                 // R13
    dataRead  = !csS && !rdS && selS;
    burstReq  = csS ? calLatch : calS;                   // R16
    ilvReq    = csS ? !ilvLatch : !ilvS;                 // R21
  end

  // Next-state logic of the whole sequencer
  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_phase       = phase + `SEQ_DIV_W'(1);            // R23
    next_holdPending = holdPending;
    next_convIlv     = convIlv;
    next_expIdx      = expIdx;
    next_xferUpdate  = 1'b0;
    next_convDoneN   = conv_done_n;
    next_trackDoneN  = track_done_n;
    next_eotCnt      = eotCnt;
    next_eotRun      = eotRun;
    next_eocAge      = eocAge;
    next_holdPrev    = holdS;
    next_csPrev      = csS;
    next_calLatch    = calLatch;
    next_ilvLatch    = ilvLatch;

    // Requests latch on the rising edge of chip select
    if (!csPrev && csS) begin
      next_calLatch = calS;                              // R16
      next_ilvLatch = ilvS;
    end

    // Age of the low conversion-done, for standalone strobing
    if (!conv_done_n && eocAge != `SEQ_EOC_MIN_AGE) begin
      next_eocAge = eocAge + `SEQ_EOC_AGE_W'(1);
    end

    // A data read raises conversion-done
    if (!conv_done_n && dataRead && eocAge == `SEQ_EOC_MIN_AGE) begin
      next_convDoneN = 1'b1;                             // R2
    end

    // End-of-track counts from the fall of conversion-done
    if (eotRun) begin
      if (eotCnt == `SEQ_EOT_CLKS - `SEQ_EOT_W'(1)) begin
        next_trackDoneN = 1'b0;                          // R8
        next_eotRun     = 1'b0;
      end else begin
        next_eotCnt = eotCnt + `SEQ_EOT_W'(1);
      end
    end

    // Hold falls outside conversion and full calibration are remembered until a phase boundary takes them
    if (holdFall && state != adc_seq_pkg::SEQ_CONVERT && state != adc_seq_pkg::SEQ_FULL_CAL) begin
      next_holdPending = 1'b1;                           // R1
    end

    unique case (state)
      adc_seq_pkg::SEQ_FULL_CAL: begin
        if (cnt == '0) begin
          next_state  = adc_seq_pkg::SEQ_TRACK;
          next_expIdx = '0;
          if (!dataRead) begin                           // R15
            next_convDoneN = 1'b0;                       // R14
            next_eocAge    = '0;
            next_eotRun    = 1'b1;
            next_eotCnt    = '0;
          end
        end else begin
          next_cnt = cnt - `SEQ_CNT_W'(1);               // R12
        end
      end
      adc_seq_pkg::SEQ_TRACK: begin
        if ((holdPending || holdFall) && tick) begin
          // Conversion begins on the internal clock boundary
          next_state       = adc_seq_pkg::SEQ_CONVERT;   // R23 R7 R9
          next_holdPending = 1'b0;
          next_convIlv     = ilvReq;
          next_cnt         = ilvReq ? (`SEQ_CONV_CLKS + `SEQ_ILV_CLKS - `SEQ_CNT_W'(1))
                                    : (`SEQ_CONV_CLKS - `SEQ_CNT_W'(1));   // R21
          next_convDoneN   = 1'b1;                       // R2
          next_trackDoneN  = 1'b1;
          next_eotRun      = 1'b0;
        end else if (burstReq && !holdPending && !holdFall) begin
          // Burst precedes interleave and resumes the shared sequence
          next_state = adc_seq_pkg::SEQ_BURST;           // R16 R22
          next_cnt   = `SEQ_EXP_CLKS - `SEQ_CNT_W'(1);
          next_trackDoneN = 1'b1;
          next_eotRun     = 1'b0;
        end
      end
      adc_seq_pkg::SEQ_CONVERT: begin
        if (cnt == '0) begin
          // Conversion done, back to tracking
          next_state     = adc_seq_pkg::SEQ_TRACK;       // R1
          next_convDoneN = 1'b0;                         // R2
          next_eocAge    = '0;
          next_eotRun    = 1'b1;
          next_eotCnt    = '0;
          if (convIlv) begin
            next_expIdx     = exp_next(expIdx);          // R20
            next_xferUpdate = exp_wraps(expIdx);         // R20
          end
        end else begin
          next_cnt = cnt - `SEQ_CNT_W'(1);
        end
      end
      adc_seq_pkg::SEQ_BURST: begin
        if (cnt == '0) begin
          // Each finished experiment advances the kept position
          next_expIdx     = exp_next(expIdx);            // R17 R22
          next_xferUpdate = exp_wraps(expIdx);
          if (burstReq) begin
            next_cnt = `SEQ_EXP_CLKS - `SEQ_CNT_W'(1);   // R16
          end else begin
            next_state     = adc_seq_pkg::SEQ_TRACK;
            next_convDoneN = 1'b0;                       // R19
            next_eocAge    = '0;
            next_eotRun    = 1'b1;
            next_eotCnt    = '0;
          end
        end else begin
          next_cnt = cnt - `SEQ_CNT_W'(1);
        end
      end
    endcase

    // Software reset overrides every activity
    if (softReset) begin
      next_state       = adc_seq_pkg::SEQ_FULL_CAL;      // R11 R13
      next_cnt         = FULLCAL_LOAD;
      next_holdPending = 1'b0;
      next_convIlv     = 1'b0;
      next_expIdx      = '0;
      next_xferUpdate  = 1'b0;
      next_convDoneN   = 1'b1;                           // R14
      next_trackDoneN  = 1'b1;
      next_eotRun      = 1'b0;
      next_eotCnt      = '0;
      next_eocAge      = '0;
    end
  end

  // Register every group; hardware reset clears and reloads calibration
  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= adc_seq_pkg::SEQ_FULL_CAL;         // R11 R12
      cnt          <= FULLCAL_LOAD;
      phase        <= '0;
      holdPending  <= 1'b0;
      convIlv      <= 1'b0;
      expIdx       <= '0;
      xfer_update  <= 1'b0;
      conv_done_n  <= 1'b1;                              // R14
      track_done_n <= 1'b1;
      eotCnt       <= '0;
      eotRun       <= 1'b0;
      eocAge       <= '0;
      holdPrev     <= 1'b1;
      csPrev       <= 1'b1;
      calLatch     <= 1'b0;
      ilvLatch     <= 1'b1;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      phase        <= next_phase;
      holdPending  <= next_holdPending;
      convIlv      <= next_convIlv;
      expIdx       <= next_expIdx;
      xfer_update  <= next_xferUpdate;
      conv_done_n  <= next_convDoneN;
      track_done_n <= next_trackDoneN;
      eotCnt       <= next_eotCnt;
      eotRun       <= next_eotRun;
      eocAge       <= next_eocAge;
      holdPrev     <= next_holdPrev;
      csPrev       <= next_csPrev;
      calLatch     <= next_calLatch;
      ilvLatch     <= next_ilvLatch;
    end
  end

  // Status levels decoded from the state register
  always_comb begin
    tracking    = (state == adc_seq_pkg::SEQ_TRACK);
    converting  = (state == adc_seq_pkg::SEQ_CONVERT);
    calibrating = (state == adc_seq_pkg::SEQ_FULL_CAL) || (state == adc_seq_pkg::SEQ_BURST);
  end

endmodule : adc_conv_cal_sequencer
`default_nettype wire

// ### core/adc_seq_defs.svh
/*
  Timing counts, reset values and widths of the converter control sequencer.
  Assumes a 25 MHz master clock; all timing counts are in master clock cycles.
*/
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// Internal conversion clock is the master clock divided by four
`define SEQ_DIV_W        2
`define SEQ_DIV_LAST     2'h3

// Conversion length and the extra length of an appended experiment
`define SEQ_CNT_W        21
`define SEQ_CONV_CLKS    21'd49
`define SEQ_ILV_CLKS     21'd20
`define SEQ_EXP_CLKS     21'd20

// Full calibration after reset, in master clocks
`define SEQ_FULLCAL_CLKS 1443840

// End-of-track delay after conversion-done falls
`define SEQ_EOT_W        4
`define SEQ_EOT_CLKS     4'd15

// Least low time of conversion-done before a read may raise it
`define SEQ_EOC_AGE_W    2
`define SEQ_EOC_MIN_AGE  2'h3

// Experiments in one complete calibration sequence
`define SEQ_EXP_W        17
`define SEQ_EXP_LAST     17'd72191

// Pin synchroniser: width and idle value of the pins
// Bit order: hold_n, cs_n, rd_n, byte_reg_select, cal_request, interleave_cal_n
`define SEQ_SYNC_W       6
`define SEQ_SYNC_INIT    6'h3d

`endif

// ### core/adc_seq_pkg.sv
/*
  Types of the converter control sequencer.
  Assumes adc_seq_defs.svh supplies the numeric constants.
*/
`default_nettype none
package adc_seq_pkg;

  // Top-level activity of the sequencer
  typedef enum logic [1:0] {
    SEQ_FULL_CAL,
    SEQ_TRACK,
    SEQ_CONVERT,
    SEQ_BURST
  } seq_state_e;

endpackage : adc_seq_pkg
`default_nettype wire

// ### core/adc_seq_sync.sv
/*
  Two-flop synchroniser for the asynchronous control pins.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_seq_sync (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Raw pins and their synchronised copy
  input  wire logic [`SEQ_SYNC_W-1:0] pinIn,
  output logic      [`SEQ_SYNC_W-1:0] pinSync
);

  logic [`SEQ_SYNC_W-1:0] stage1;
  logic [`SEQ_SYNC_W-1:0] next_stage1;
  logic [`SEQ_SYNC_W-1:0] next_pinSync;

  // First stage feeds only the second
  always_comb begin
    next_stage1  = pinIn;
    next_pinSync = stage1;
  end

  // Both stages start at the idle pin levels
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1  <= `SEQ_SYNC_INIT;
      pinSync <= `SEQ_SYNC_INIT;
    end else begin
      stage1  <= next_stage1;
      pinSync <= next_pinSync;
    end
  end

endmodule : adc_seq_sync
`default_nettype wire

// ### verif/adc_seq_props.sv
/*
  Port assertions of the conversion and calibration sequencer.
  Assumes it is bound into every sequencer instance, with the same calibration length.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_seq_props #(
  parameter int unsigned FULLCAL_CLKS = 40
) (
  // Clock, reset and pins
  input wire logic clk, rst, hold_n, cs_n, rd_n, byte_reg_select, cal_request, interleave_cal_n,
  // Sequencer outputs
  input wire logic conv_done_n, track_done_n, tracking, converting, calibrating, xfer_update
);
  logic [6:0]  runLen;
  logic [31:0] calCnt;
  logic [3:0]  rdHist;
  logic [1:0]  gap;
  logic        hwCal;
  logic        started;
  wire logic   readOn = !cs_n && !rd_n && byte_reg_select;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Run lengths, read history and start spacing
  always_ff @(posedge clk) begin
    runLen <= converting ? runLen + 7'h1 : 7'h0;
    rdHist <= {rdHist[2:0], readOn};
    gap <= $rose(converting) ? 2'h1 : gap + 2'h1;
    calCnt <= (calibrating && !rst) ? calCnt + 32'h1 : 32'h0;
    if (rst) hwCal <= 1'h1;
    else if (!calibrating || (!cs_n && !byte_reg_select && !hold_n)) hwCal <= 1'h0;
    if (rst || calibrating) started <= 1'h0;
    else if ($rose(converting)) started <= 1'h1;
  end
  sequence eocLow;
    !conv_done_n [*3];
  endsequence
  sequence readHeld;
    readOn [*4];
  endsequence
  AST_CONV_LEN: assert property (
    $fell(converting) && !calibrating |-> tracking && runLen inside {7'd49, 7'd69}) else $error("bad conversion length");
  AST_EOT_DELAY: assert property (
    $fell(conv_done_n) |-> ##14 (track_done_n || converting || calibrating)
    ##1 (!track_done_n || converting || calibrating)) else $error("end of track not 15 clocks late");
  AST_RST_VALUES: assert property (
    $past(rst) |-> conv_done_n && track_done_n && calibrating && !tracking && !converting && !xfer_update)
    else $error("bad outputs in reset");
  AST_FULLCAL_LEN: assert property (
    $fell(calibrating) && hwCal |-> calCnt == FULLCAL_CLKS) else $error("bad full calibration length");
  AST_EOC_AFTER_CAL: assert property (
    $fell(calibrating) && rdHist == 4'h0 |-> !conv_done_n) else $error("done not low after calibration");
  AST_STANDALONE: assert property (
    $fell(calibrating) && hwCal && rdHist == 4'hf |-> conv_done_n) else $error("done fell under reads");
  AST_EOC_READ: assert property (
    eocLow ##1 readHeld |=> conv_done_n) else $error("read did not raise done");
  AST_EOC_START: assert property (
    $rose(converting) |-> conv_done_n && track_done_n) else $error("flags low at start");
  AST_PHASE: assert property (
    $rose(converting) && started |-> gap == 2'h0) else $error("start off the phase boundary");
endmodule : adc_seq_props
bind adc_conv_cal_sequencer adc_seq_props #(.FULLCAL_CLKS(FULLCAL_CLKS)) adc_seq_props_i (
  .clk(clk), .rst(rst), .hold_n(hold_n), .cs_n(cs_n), .rd_n(rd_n), .byte_reg_select(byte_reg_select),
  .cal_request(cal_request), .interleave_cal_n(interleave_cal_n), .conv_done_n(conv_done_n),
  .track_done_n(track_done_n), .tracking(tracking), .converting(converting), .calibrating(calibrating),
  .xfer_update(xfer_update));
`default_nettype wire

// ### verif/sample_trigger.sv
/*
  Sampling logic on the far side of the hold pin.
  Assumes the bench picks the mode: 0 manual, 1 loopback, 2 counter.
*/
`timescale 1ns/10ps
`default_nettype none
module sample_trigger #(
  parameter int ACQ_CLKS = 63
) (
  // Clock and control
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  input  wire logic       holdReq,
  // Sequencer outputs and hold drive
  input  wire logic       conv_done_n,
  input  wire logic       track_done_n,
  output logic            hold_n
);
  int   cnt = 1000;
  logic eocLast = 1'h1;
  // Count from the fall of conversion-done
  always @(posedge clk) begin
    eocLast <= conv_done_n;
    if (eocLast && !conv_done_n) cnt <= 0;
    else if (cnt < 1000) cnt <= cnt + 1;
  end
  // Hold from the bench, from end-of-track or from the counter
  assign hold_n = (mode == 2'h1) ? track_done_n
                : (mode == 2'h2) ? !(cnt >= ACQ_CLKS && cnt < ACQ_CLKS + 2)
                : !holdReq;
endmodule : sample_trigger
`default_nettype wire

// ### verif/test_adc_conv_cal_sequencer.sv
/*
  Self-checking bench of the conversion and calibration sequencer.
  Assumes the sample_trigger partner drives hold and a short full calibration.
*/
`timescale 1ns/10ps
`default_nettype none
module test_adc_conv_cal_sequencer;
  localparam int CAL = 40;
  localparam int ACQ = 63;  // Six clocks plus 2.25 us
  // Stimulus, outputs and model state
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       csN = 1'h1;
  logic       rdN = 1'h1;
  logic       sel = 1'h1;
  logic       calReq = 1'h0;
  logic       ilvN = 1'h1;
  logic       holdReq = 1'h0;
  logic [1:0] mode = 2'h0;
  logic       holdN, eocN, eotN, trk, cnv, cal, upd;
  wire logic [3:0] st = {eotN, eocN, cal, cnv};
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         n;
  int         ilvOn = 0;
  int         expLen[$];
  bit  [15:0] seed = 16'h7ef4;
  // Master clock
  always #20 clk = ~clk;
  adc_conv_cal_sequencer #(.FULLCAL_CLKS(CAL)) adc_conv_cal_sequencer_i (.clk(clk), .rst(rst), .hold_n(holdN),
    .cs_n(csN), .rd_n(rdN), .byte_reg_select(sel), .cal_request(calReq), .interleave_cal_n(ilvN),
    .conv_done_n(eocN), .track_done_n(eotN), .tracking(trk), .converting(cnv), .calibrating(cal),
    .xfer_update(upd));
  sample_trigger sample_trigger_i (.clk(clk), .mode(mode), .holdReq(holdReq), .conv_done_n(eocN),
    .track_done_n(eotN), .hold_n(holdN));
  function automatic bit [15:0] lfsr(input bit [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask : ticks
  task automatic waitSig(input int id, input logic v);
    @(negedge clk);
    for (n = 0; st[id] !== v && n < 3000; n++) @(negedge clk);
    check(st[id], v);
  endtask : waitSig
  task automatic span(input int id, output int len);
    for (len = 0; st[id] === 1'h1 && len < 3000; len++) @(negedge clk);
  endtask : span
  // Start a conversion, time it and the end-of-track delay
  task automatic convert(input logic viaHold);
    int len;
    expLen.push_back(49 + 20 * ilvOn);
    if (viaHold) begin
      holdReq <= 1'h1;
      ticks(3);
      holdReq <= 1'h0;
    end
    waitSig(0, 1'h1);
    if (viaHold) check(n < 4, 1'h1);
    check(eocN, 1'h1);
    span(0, len);
    check(len, expLen.pop_front());
    check({trk, eocN}, 2'h2);
    span(3, len);
    check(len, 15);
  endtask : convert
  // Select cycle with request levels held throughout
  task automatic bus(input logic rd, input logic cr, input logic il);
    @(posedge clk);
    csN <= 1'h0;
    sel <= 1'h1;
    rdN <= !rd;
    calReq <= cr;
    ilvN <= il;
    ticks(5);
    csN <= 1'h1;
    rdN <= 1'h1;
  endtask : bus
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    ticks(8);
    rst <= 1'h0;
    @(negedge clk);
    span(1, n);
    check(n, CAL);
    check({trk, eocN}, 2'h2);
    repeat (3) begin
      seed = lfsr(seed);
      ticks(ACQ + seed[2:0]);
      convert(1'h1);
    end
    bus(1'h1, 1'h0, 1'h1);
    @(negedge clk);
    check(eocN, 1'h1);
    bus(1'h0, 1'h0, 1'h0);
    ilvOn = 1;
    ticks(ACQ);
    convert(1'h1);
    check(upd, 1'h0);
    bus(1'h0, 1'h0, 1'h1);
    ilvOn = 0;
    ticks(ACQ);
    bus(1'h1, 1'h1, 1'h1);
    ticks(60);
    waitSig(1, 1'h1);
    check(eocN, 1'h1);
    bus(1'h0, 1'h0, 1'h1);
    waitSig(1, 1'h0);
    check(eocN, 1'h0);
    ticks(26 + 57);
    convert(1'h1);
    ticks(1);
    mode <= 2'h1;
    repeat (3) convert(1'h0);
    ticks(1);
    mode <= 2'h2;
    ticks(12);
    waitSig(0, 1'h0);
    convert(1'h0);
    ticks(1);
    mode <= 2'h0;
    ticks(ACQ);
    holdReq <= 1'h1;
    ticks(2);
    holdReq <= 1'h0;
    waitSig(0, 1'h1);
    ticks(1);
    csN <= 1'h0;
    sel <= 1'h0;
    holdReq <= 1'h1;
    ticks(4);
    csN <= 1'h1;
    sel <= 1'h1;
    holdReq <= 1'h0;
    @(negedge clk);
    check({cal, cnv}, 2'h2);
    waitSig(1, 1'h0);
    check(eocN, 1'h0);
    ticks(1);
    csN <= 1'h0;
    rdN <= 1'h0;
    rst <= 1'h1;
    ticks(8);
    rst <= 1'h0;
    waitSig(1, 1'h0);
    ticks(3);
    @(negedge clk);
    check(eocN, 1'h1);
    conclude();
  end
  // Watchdog at several times the expected run
  initial begin
    ticks(20000);
    error_cnt++;
    conclude();
  end
endmodule : test_adc_conv_cal_sequencer
`default_nettype wire
